// ===== verilog/xpmc_pkg.sv
// constants, register map and carrier structs of the port mac configuration block
// assumes an apb master on ref_clk and strap pins that are stable around reset release
//
// Contract
// - the duplex bit selects full duplex when 1 and half duplex when 0, and resets to 1.
// - the transmit flow control bit enables transmit flow control when 1.
// - the receive flow control bit enables receive flow control when 1.
// - flow control enables, gigabit select, clocking mode and interface type reset from straps.
// - below gigabit the 10/100 bit picks 100 Mb/s when 1, 10 Mb/s when 0, and resets to 1.
// - the gigabit bit at 0 runs the port at 1000 Mb/s, at 1 defers to the 10/100 bit.
// - the ingress delay bit adds at least 1.5 ns on the incoming clock and resets to 0.
// - the egress delay bit adds a minimum delay on the outgoing clock and resets to 1.
// - in mii mode the clocking bit at 1 receives clocks, at 0 drives them as a phy.
// - in rmii mode the clocking bit at 1 receives the 50 MHz reference, at 0 drives it.
// - the type field picks rgmii for 00, rmii for 01 and mii for 10 and 11.
// - the storm protection bit applies broadcast storm protection to ingress when 1.
// - back pressure applies only while running half duplex and its enable is set.
// - full duplex uses pause flow control from the flow control enables, not back pressure.
// - bad frames are dropped unless pass-all is 1, then forwarded for mirroring only.
// - flow control frame filtering is left untouched by the pass-all bit.
package xpmc_pkg;

  localparam logic [11:0] XPMC_OFF_XMII_ZERO = 12'h300;
  localparam logic [11:0] XPMC_OFF_XMII_ONE  = 12'h301;
  localparam logic [11:0] XPMC_OFF_MAC_ZERO  = 12'h400;
  localparam logic [11:0] XPMC_OFF_MAC_ONE   = 12'h401;

  localparam int XPMC_BIT_DUPLEX   = 6;
  localparam int XPMC_BIT_TX_FC    = 5;
  localparam int XPMC_BIT_SPEED100 = 4;
  localparam int XPMC_BIT_RX_FC    = 3;
  localparam int XPMC_BIT_GIG_N    = 6;
  localparam int XPMC_BIT_RSVD5    = 5;
  localparam int XPMC_BIT_IG_DLY   = 4;
  localparam int XPMC_BIT_EG_DLY   = 3;
  localparam int XPMC_BIT_CLK_MODE = 2;
  localparam int XPMC_BIT_STORM    = 1;
  localparam int XPMC_BIT_MAC0_R3  = 3;
  localparam int XPMC_BIT_MAC0_R0  = 0;
  localparam int XPMC_BIT_BP       = 3;
  localparam int XPMC_BIT_PASS_ALL = 0;

  localparam logic [7:0] XPMC_RW_XMII_ZERO = 8'h7F;
  localparam logic [7:0] XPMC_RW_XMII_ONE  = 8'hFF;
  localparam logic [7:0] XPMC_RW_MAC_ZERO  = 8'h0B;
  localparam logic [7:0] XPMC_RW_MAC_ONE   = 8'hBF;

  localparam logic       XPMC_RST_DUPLEX   = 1'b1;
  localparam logic       XPMC_RST_SPEED100 = 1'b1;
  localparam logic       XPMC_RST_IG_DLY   = 1'b0;
  localparam logic       XPMC_RST_EG_DLY   = 1'b1;
  localparam logic [7:0] XPMC_RST_ZERO     = 8'h00;
  // edges the strap synchroniser needs to refill after reset release
  localparam logic [1:0] XPMC_STRAP_SETTLE = 2'h2;

  localparam real XPMC_IG_DELAY_NS = 1.5;
  localparam real XPMC_CLK_NS      = 4.0;
  localparam int  XPMC_IG_DELAY_CYC = (XPMC_IG_DELAY_NS / XPMC_CLK_NS) < 1.0 ? 1 : 1;
  localparam real XPMC_RMII_REF_MHZ = 50.0;

  typedef enum logic [1:0] {
    XPMC_IF_RGMII = 2'b00,
    XPMC_IF_RMII  = 2'b01,
    XPMC_IF_MII   = 2'b10
  } xpmc_if_e;

  typedef enum logic [1:0] {
    XPMC_SPD_10   = 2'b00,
    XPMC_SPD_100  = 2'b01,
    XPMC_SPD_1000 = 2'b10
  } xpmc_speed_e;

  typedef struct packed {
    logic [7:0] xmii_zero;
    logic [7:0] xmii_one;
    logic [7:0] mac_zero;
    logic [7:0] mac_one;
  } xpmc_regs_s;

  typedef struct packed {
    xpmc_if_e    if_type;
    xpmc_speed_e speed;
    logic        full_duplex;
    logic        clk_receive;
  } xpmc_mode_s;

  typedef struct packed {
    logic        prdy;
    logic [31:0] prdata;
    logic        pslverr;
  } xpmc_apb_rsp_s;

  typedef struct packed {
    logic        tx_fc_en;
    logic        rx_fc_en;
    logic        pause_en;
    logic        back_pressure;
    logic        storm_protect;
    logic        pass_bad_frames;
    logic        ig_delay_en;
    logic        eg_delay_en;
    logic        clk_out_en;
    logic        ref_clk_out_en;
  } xpmc_ctrl_s;

endpackage : xpmc_pkg

// ===== verilog/xpmc_top.sv
// port mac configuration registers on apb with frame-boundary mode update
// assumes frame_active comes from the port datapath on ref_clk; straps are pins
`timescale 1ns/1ps
`default_nettype none
module xpmc_top
  import xpmc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        flow_control_default_strap,
  input  wire logic        port_speed_strap,
  input  wire logic        port_clocking_mode_strap,
  input  wire logic [1:0]  port_interface_type_strap,
  input  wire logic        frame_active,
  output xpmc_mode_s       mode,
  output xpmc_ctrl_s       ctrl
);

  typedef struct packed {
    logic [1:0]    strap_s1;
    logic [1:0]    strap_s2;
    logic [4:0]    pin_s1;
    logic [4:0]    pin_s2;
    logic [1:0]    settle;
    logic          loaded;
    xpmc_regs_s    regs;
    xpmc_mode_s    mode;
    xpmc_ctrl_s    ctrl;
    xpmc_apb_rsp_s rsp;
  } xpmc_state_s;

  xpmc_state_s st_q;
  xpmc_state_s st_d;

  logic       sel_x0;
  logic       sel_x1;
  logic       sel_m0;
  logic       sel_m1;
  logic [7:0] rd_byte;
  logic       wr_en;
  xpmc_mode_s want;

  always_comb begin
    sel_x0 = 1'b0;
    sel_x1 = 1'b0;
    sel_m0 = 1'b0;
    sel_m1 = 1'b0;
    rd_byte = 8'h00;
    if (paddr[13:2] == XPMC_OFF_XMII_ZERO) begin
      sel_x0 = 1'b1;
      rd_byte = st_q.regs.xmii_zero;
    end else if (paddr[13:2] == XPMC_OFF_XMII_ONE) begin
      sel_x1 = 1'b1;
      rd_byte = st_q.regs.xmii_one;
    end else if (paddr[13:2] == XPMC_OFF_MAC_ZERO) begin
      sel_m0 = 1'b1;
      rd_byte = st_q.regs.mac_zero;
    end else if (paddr[13:2] == XPMC_OFF_MAC_ONE) begin
      sel_m1 = 1'b1;
      rd_byte = st_q.regs.mac_one;
    end
  end

  always_comb begin
    st_d = st_q;
    st_d.strap_s1 = {flow_control_default_strap, port_speed_strap};
    st_d.strap_s2 = st_q.strap_s1;
    st_d.pin_s1 = {port_clocking_mode_strap, port_interface_type_strap, 2'b00};
    st_d.pin_s2 = st_q.pin_s1;
    wr_en = 1'b0;

    // apb: no wait states, response in the cycle after setup
    st_d.rsp.prdy = 1'b0;
    st_d.rsp.pslverr = 1'b0;
    if (psel && !penable) begin
      st_d.rsp.prdy = 1'b1;
      st_d.rsp.pslverr = !(sel_x0 || sel_x1 || sel_m0 || sel_m1);
      st_d.rsp.prdata = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
    end
    // a write lands only at the edge that completes the access phase
    wr_en = psel && penable && st_q.rsp.prdy && pwrite && pstrb[0] && st_q.loaded;
    if (wr_en && sel_x0) begin
      st_d.regs.xmii_zero = pwdata[7:0] & XPMC_RW_XMII_ZERO;
    end
    if (wr_en && sel_x1) begin
      st_d.regs.xmii_one = pwdata[7:0] & XPMC_RW_XMII_ONE;
    end
    if (wr_en && sel_m0) begin
      st_d.regs.mac_zero = pwdata[7:0] & XPMC_RW_MAC_ZERO;
    end
    if (wr_en && sel_m1) begin
      st_d.regs.mac_one = pwdata[7:0] & XPMC_RW_MAC_ONE;
    end

    // straps captured once after reset release, after the synchroniser has refilled
    if (!st_q.loaded) begin
      if (st_q.settle != XPMC_STRAP_SETTLE) begin
        st_d.settle = st_q.settle + 2'h1;
      end else begin
        st_d.loaded = 1'b1;
        st_d.regs.xmii_zero[XPMC_BIT_TX_FC] = st_q.strap_s2[1];
        st_d.regs.xmii_zero[XPMC_BIT_RX_FC] = st_q.strap_s2[1];
        st_d.regs.xmii_one[XPMC_BIT_GIG_N] = st_q.strap_s2[0];
        st_d.regs.xmii_one[XPMC_BIT_CLK_MODE] = st_q.pin_s2[4];
        st_d.regs.xmii_one[1:0] = st_q.pin_s2[3:2];
      end
    end

    // decode the requested mode
    want.full_duplex = st_q.regs.xmii_zero[XPMC_BIT_DUPLEX];
    if (!st_q.regs.xmii_one[XPMC_BIT_GIG_N]) begin
      want.speed = XPMC_SPD_1000;
    end else if (st_q.regs.xmii_zero[XPMC_BIT_SPEED100]) begin
      want.speed = XPMC_SPD_100;
    end else begin
      want.speed = XPMC_SPD_10;
    end
    if (st_q.regs.xmii_one[1:0] == XPMC_IF_RGMII) begin
      want.if_type = XPMC_IF_RGMII;
    end else if (st_q.regs.xmii_one[1:0] == XPMC_IF_RMII) begin
      want.if_type = XPMC_IF_RMII;
    end else begin
      want.if_type = XPMC_IF_MII;
    end
    want.clk_receive = st_q.regs.xmii_one[XPMC_BIT_CLK_MODE];

    // mode changes wait for an idle gap between frames
    if (!frame_active) begin
      st_d.mode = want;
    end

    st_d.ctrl.tx_fc_en = st_q.regs.xmii_zero[XPMC_BIT_TX_FC];
    st_d.ctrl.rx_fc_en = st_q.regs.xmii_zero[XPMC_BIT_RX_FC];
    st_d.ctrl.pause_en = st_q.mode.full_duplex &&
                         (st_q.regs.xmii_zero[XPMC_BIT_TX_FC] ||
                          st_q.regs.xmii_zero[XPMC_BIT_RX_FC]);
    st_d.ctrl.back_pressure = !st_q.mode.full_duplex &&
                              st_q.regs.mac_one[XPMC_BIT_BP];
    st_d.ctrl.storm_protect = st_q.regs.mac_zero[XPMC_BIT_STORM];
    // pass-all only touches bad-frame dropping, never pause filtering
    st_d.ctrl.pass_bad_frames = st_q.regs.mac_one[XPMC_BIT_PASS_ALL];
    st_d.ctrl.ig_delay_en = (st_q.mode.if_type == XPMC_IF_RGMII) &&
                            st_q.regs.xmii_one[XPMC_BIT_IG_DLY];
    st_d.ctrl.eg_delay_en = (st_q.mode.if_type == XPMC_IF_RGMII) &&
                            st_q.regs.xmii_one[XPMC_BIT_EG_DLY];
    st_d.ctrl.clk_out_en = (st_q.mode.if_type == XPMC_IF_MII) &&
                           !st_q.mode.clk_receive;
    st_d.ctrl.ref_clk_out_en = (st_q.mode.if_type == XPMC_IF_RMII) &&
                               !st_q.mode.clk_receive;

    if (!rst_b) begin
      st_d = '0;
      st_d.regs.xmii_zero[XPMC_BIT_DUPLEX] = XPMC_RST_DUPLEX;
      st_d.regs.xmii_zero[XPMC_BIT_SPEED100] = XPMC_RST_SPEED100;
      st_d.regs.xmii_one[XPMC_BIT_IG_DLY] = XPMC_RST_IG_DLY;
      st_d.regs.xmii_one[XPMC_BIT_EG_DLY] = XPMC_RST_EG_DLY;
      st_d.regs.mac_zero = XPMC_RST_ZERO;
      st_d.regs.mac_one = XPMC_RST_ZERO;
      st_d.mode.full_duplex = XPMC_RST_DUPLEX;
    end
  end

  always_ff @(posedge ref_clk) begin
    st_q <= st_d;
  end

  assign pready  = st_q.rsp.prdy;
  assign prdata  = st_q.rsp.prdata;
  assign pslverr = st_q.rsp.pslverr;
  assign mode    = st_q.mode;
  assign ctrl    = st_q.ctrl;

endmodule : xpmc_top
`default_nettype wire

// ===== sim/xpmc_chk.sv
// assertions on the pins of the port configuration block
// assumes binding into xpmc_top, all inputs named as its ports
`timescale 1ns/1ps
`default_nettype none
module xpmc_chk
  import xpmc_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        frame_active,
  input wire xpmc_mode_s  mode,
  input wire xpmc_ctrl_s  ctrl
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_setup; psel && !penable; endsequence
  sequence s_ack; psel && penable && pready; endsequence
  property p_ack; s_setup |=> s_ack; endproperty
  a_ack: assert property (p_ack) else $error("no answer after setup");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("error without ready or with data");
  property p_byte; pready |-> prdata[31:8] == 24'h0; endproperty
  a_byte: assert property (p_byte) else $error("read data upper bits set");
  property p_hold; frame_active |=> $stable(mode); endproperty
  a_hold: assert property (p_hold) else $error("mode changed in frame");
  property p_type; mode.if_type != 2'b11; endproperty
  a_type: assert property (p_type) else $error("bad interface code");
  property p_speed; mode.speed != 2'b11; endproperty
  a_speed: assert property (p_speed) else $error("bad speed code");
  property p_bp; ctrl.back_pressure |-> !$past(mode.full_duplex); endproperty
  a_bp: assert property (p_bp) else $error("back pressure at full duplex");
  property p_pause; ctrl.pause_en |-> $past(mode.full_duplex) && (ctrl.tx_fc_en || ctrl.rx_fc_en);
  endproperty
  a_pause: assert property (p_pause) else $error("pause without cause");
  property p_mii; ctrl.clk_out_en |-> $past(mode.if_type) == XPMC_IF_MII && !$past(mode.clk_receive);
  endproperty
  a_mii: assert property (p_mii) else $error("clock drive outside mii phy mode");
  property p_rmii; ctrl.ref_clk_out_en |-> $past(mode.if_type) == XPMC_IF_RMII && !$past(mode.clk_receive);
  endproperty
  a_rmii: assert property (p_rmii) else $error("reference drive outside rmii");
endmodule : xpmc_chk
`default_nettype wire

// ===== sim/xpmc_far_model.sv
// far side frame source: frame_active lasts a count of link clock edges
// assumes link_clk slower than ref_clk and sampled here
`timescale 1ns/1ps
`default_nettype none
module xpmc_far_model #(
  parameter int FRAME_LEN = 8
) (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic link_clk,
  input  wire logic send,
  output logic      frame_active
);
  logic [2:0] lk_q;
  int         cnt_q;
  always_ff @(posedge ref_clk) begin
    lk_q <= {lk_q[1:0], link_clk};
    if (!rst_b) begin
      cnt_q        <= 0;
      frame_active <= 1'b0;
    end else if (send && !frame_active) begin
      cnt_q        <= FRAME_LEN;
      frame_active <= 1'b1;
    end else if (frame_active && lk_q[2:1] == 2'b01) begin
      cnt_q        <= cnt_q - 1;
      frame_active <= (cnt_q > 1);
    end
  end
endmodule : xpmc_far_model
`default_nettype wire

// ===== sim/xmii_port_mac_config_tb.sv
// self-checking bench: apb master, frame source, register rows
// assumes straps start at fc 1, speed 1, clocking 0, type 01 and change over a mid-run reset
`timescale 1ns/1ps
`default_nettype none
module xmii_port_mac_config_tb
  import xpmc_pkg::*;
;
  typedef struct packed {logic [7:0] x0, x1, m0, m1; logic [5:0] md;} xpmc_row_s;
  logic ref_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic link_clk = 0, send = 0, frame_active, rerr;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rdat;
  logic [3:0] pstrb = 0;
  logic fc_strap = 1'b1, spd_strap = 1'b1, clkm_strap = 1'b0;
  logic [1:0] type_strap = 2'b01;
  xpmc_mode_s mode;
  xpmc_ctrl_s ctrl;
  int n_errors = 0, samples_checked = 0;
  xpmc_row_s rows[4] = '{'{8'hE8, 8'h00, 8'h02, 8'h09, 6'h0A}, '{8'h28, 8'h45, 8'h00, 8'h08, 6'h11},
                         '{8'h50, 8'h5A, 8'h02, 8'h01, 6'h26}, '{8'h10, 8'h47, 8'h00, 8'h08, 6'h25}};
  always #2 ref_clk = ~ref_clk;
  always #40 link_clk = frame_active ? ~link_clk : 1'b0;
  xpmc_top dut(.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
    .prdata, .pslverr, .flow_control_default_strap(fc_strap), .port_speed_strap(spd_strap),
    .port_clocking_mode_strap(clkm_strap), .port_interface_type_strap(type_strap), .frame_active,
    .mode, .ctrl);
  xpmc_far_model far(.ref_clk, .rst_b, .link_clk, .send, .frame_active);
  function automatic logic [9:0] exp_ctrl(logic [7:0] x0, x1, m0, m1, logic [5:0] m);
    return {x0[5], x0[3], m[1] & (x0[5] | x0[3]), m1[3] & ~m[1], m0[1], m1[0],
            x1[4] & (m[5:4] == 2'b00), x1[3] & (m[5:4] == 2'b00),
            m[5:4] == 2'b10 && !m[0], m[5:4] == 2'b01 && !m[0]};
  endfunction : exp_ctrl
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, s);
      n_errors++;
    end
  endtask : chk
  task automatic apb(logic w, logic [11:0] i, logic [7:0] d, logic st);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {18'h0, i, 2'h0};
    pwdata <= {24'h0, d};
    pstrb <= {3'h0, st};
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic rdchk(string nm, logic [11:0] i, logic [7:0] e);
    apb(1'b0, i, 8'h00, 1'b0);
    chk(nm, {24'h0, e}, rdat);
  endtask : rdchk
  task automatic wr4(xpmc_row_s r);
    apb(1'b1, XPMC_OFF_XMII_ZERO, r.x0, 1'b1);
    apb(1'b1, XPMC_OFF_XMII_ONE, r.x1, 1'b1);
    apb(1'b1, XPMC_OFF_MAC_ZERO, r.m0, 1'b1);
    apb(1'b1, XPMC_OFF_MAC_ONE, r.m1, 1'b1);
    repeat (4) @(posedge ref_clk);
  endtask : wr4
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_errors++;
    test_done();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rdchk("x0 reset", XPMC_OFF_XMII_ZERO, 8'h78);
    rdchk("x1 reset", XPMC_OFF_XMII_ONE, 8'h49);
    rdchk("m0 reset", XPMC_OFF_MAC_ZERO, 8'h00);
    rdchk("m1 reset", XPMC_OFF_MAC_ONE, 8'h00);
    chk("mode reset", 32'h16, {26'h0, mode});
    chk("ctrl reset", {22'h0, exp_ctrl(8'h78, 8'h49, 8'h0, 8'h0, 6'h16)}, {22'h0, ctrl});
    foreach (rows[k]) begin
      wr4(rows[k]);
      chk("mode", {26'h0, rows[k].md}, {26'h0, mode});
      chk("ctrl", {22'h0, exp_ctrl(rows[k].x0, rows[k].x1, rows[k].m0, rows[k].m1,
          rows[k].md)}, {22'h0, ctrl});
      rdchk("x0", XPMC_OFF_XMII_ZERO, rows[k].x0 & XPMC_RW_XMII_ZERO);
      rdchk("x1", XPMC_OFF_XMII_ONE, rows[k].x1);
      rdchk("m1", XPMC_OFF_MAC_ONE, rows[k].m1 & XPMC_RW_MAC_ONE);
    end
    apb(1'b1, XPMC_OFF_MAC_ZERO, 8'h02, 1'b0);
    rdchk("m0 no strobe", XPMC_OFF_MAC_ZERO, 8'h00);
    apb(1'b0, 12'h302, 8'h00, 1'b0);
    chk("unmapped error", 32'h1, {31'h0, rerr});
    chk("unmapped data", 32'h0, rdat);
    send <= 1'b1;
    @(posedge ref_clk);
    send <= 1'b0;
    apb(1'b1, XPMC_OFF_XMII_ZERO, 8'h50, 1'b1);
    repeat (4) @(posedge ref_clk);
    chk("mode in frame", 32'h25, {26'h0, mode});
    while (frame_active === 1'b1) @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
    chk("mode after frame", 32'h27, {26'h0, mode});
    fc_strap <= 1'b0;
    spd_strap <= 1'b0;
    clkm_strap <= 1'b1;
    type_strap <= 2'b00;
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rdchk("x0 rerun", XPMC_OFF_XMII_ZERO, 8'h50);
    rdchk("x1 rerun", XPMC_OFF_XMII_ONE, 8'h0C);
    rdchk("m1 rerun", XPMC_OFF_MAC_ONE, 8'h00);
    chk("mode rerun", 32'h0B, {26'h0, mode});
    chk("ctrl rerun", {22'h0, exp_ctrl(8'h50, 8'h0C, 8'h00, 8'h00, 6'h0B)},
        {22'h0, ctrl});
    test_done();
  end
endmodule : xmii_port_mac_config_tb
bind xpmc_top xpmc_chk u_chk(.ref_clk, .rst_b, .psel, .penable, .pready, .prdata, .pslverr,
  .frame_active, .mode, .ctrl);
`default_nettype wire
